// File: rtl/dam_pkg.sv
// Contract
// RQ1: Reading an indirect port through indirect addressing returns zero.
// RQ2: Writing an indirect port through indirect addressing changes nothing.
// RQ3: Accesses naming an indirect port act on the location its pointer holds.
// RQ4: Indirect port A always reaches bank 0, whatever the bank select holds.
// RQ5: Indirect port B reaches the bank chosen by the bank select register.
// RQ6: Eleven RAM banks numbered 0 to 10; bank select value equals bank number.
// RQ7: Reset clears bank select, except watchdog time-out while powered down.
// RQ8: Special-function registers sit in bank 0, reachable whatever bank is selected.
// RQ9: Direct operand addressing always reaches bank 0.
// RQ10: Both pointers are readable, writable registers in data memory.
// RQ11: Writing the counter low byte jumps within the current page.
// RQ12: A jump by counter low byte write inserts one dummy cycle.
// RQ13: ALU results go to the accumulator; no memory-to-memory moves.
// RQ14: Software loads the table pointer before any table read.
// RQ15: Table read puts the fetched word's high byte in the table high byte register.
// RQ16: Table read writes the fetched word's low byte to the operand location.
// RQ17: Watchdog time-out sets the time-out flag.
// RQ18: For banked pointer accesses, bank select forms upper address, pointer the offset.
// RQ19: Table read address is the page bits joined with the table pointer.
package dam_pkg;
    // ****************************************
    // Geometry
    // ****************************************
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int BANK_W = 4;
    localparam int NUM_BANKS = 11;
    localparam int BANK_SIZE = 192;
    localparam int PC_W = 14;
    localparam int PM_W = 16;
    localparam logic [7:0] SFR_TOP = 8'h40;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ****************************************
    // Special-function addresses
    // ****************************************
    localparam logic [7:0] SFR_PORT_A = 8'h00;
    localparam logic [7:0] SFR_POINTER_A = 8'h01;
    localparam logic [7:0] SFR_PORT_B = 8'h02;
    localparam logic [7:0] SFR_POINTER_B = 8'h03;
    localparam logic [7:0] SFR_BANK_SELECT = 8'h04;
    localparam logic [7:0] SFR_ACCUMULATOR = 8'h05;
    localparam logic [7:0] SFR_PC_LOW = 8'h06;
    localparam logic [7:0] SFR_TABLE_PTR = 8'h07;
    localparam logic [7:0] SFR_TABLE_HIGH = 8'h08;

    // ****************************************
    // APB map
    // ****************************************
    localparam logic [11:0] APB_BANK_SELECT = 12'h000;
    localparam logic [11:0] APB_POINTER_A = 12'h004;
    localparam logic [11:0] APB_POINTER_B = 12'h008;
    localparam logic [11:0] APB_ACCUMULATOR = 12'h00C;
    localparam logic [11:0] APB_TABLE_PTR = 12'h010;
    localparam logic [11:0] APB_TABLE_HIGH = 12'h014;
    localparam logic [11:0] APB_PROG_COUNTER = 12'h018;
    localparam logic [11:0] APB_STATUS = 12'h01C;
    localparam int STAT_TIMEOUT = 0;
    localparam int STAT_POWER_DOWN = 1;
    localparam int STAT_SLEEP = 2;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {DAM_IDLE, DAM_TBL_FETCH, DAM_DUMMY} dam_state_e;
endpackage : dam_pkg

// File: rtl/dam_addr_map.sv
`timescale 1ns/1ps
module dam_addr_map #(
    parameter int RAM_AW = 12
) (
    input wire logic [7:0] addr,
    input wire logic [7:0] pointer_a,
    input wire logic [7:0] pointer_b,
    input wire logic [3:0] bank_select,
    output logic sfr_sel,
    output logic ram_sel,
    output logic [7:0] sfr_addr,
    output logic [RAM_AW-1:0] ram_index
);
    logic [7:0] eff;
    logic [3:0] bank;
    logic indirect;
    logic [RAM_AW-1:0] offset;

    // ****************************************
    // Effective address resolution
    // ****************************************
    always_comb begin
        indirect = 1'b1;
        if (addr == dam_pkg::SFR_PORT_A) begin
            eff = pointer_a; // RQ3
            bank = 4'h0; // RQ4
        end else if (addr == dam_pkg::SFR_PORT_B) begin
            eff = pointer_b; // RQ3
            bank = bank_select; // RQ5
        end else begin
            indirect = 1'b0;
            eff = addr;
            bank = 4'h0; // RQ9
        end
        offset = RAM_AW'(eff - dam_pkg::SFR_TOP);
        // Port through a port: no location
        sfr_sel = (eff < dam_pkg::SFR_TOP) &&
                  !(indirect && (eff == dam_pkg::SFR_PORT_A || eff == dam_pkg::SFR_PORT_B)); // RQ1 RQ2 RQ8
        sfr_addr = eff;
        // No bank past the last
        ram_sel = (eff >= dam_pkg::SFR_TOP) && (int'(bank) < dam_pkg::NUM_BANKS); // RQ6
        ram_index = RAM_AW'(int'(bank) * dam_pkg::BANK_SIZE) + offset; // RQ18
    end
endmodule : dam_addr_map

// File: rtl/dam_ram.sv
`timescale 1ns/1ps
module dam_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2112,
    parameter int AW = 12
) (
    input wire logic pclk,
    input wire logic pce,
    input wire logic we,
    input wire logic [AW-1:0] index,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    initial begin
        if (DEPTH < 1 || (1 << AW) < DEPTH) begin
            $error("dam_ram: index too narrow");
        end
    end

    // ****************************************
    // Storage entries
    // ****************************************
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge pclk) begin
            if (pce && we && (int'(index) == i)) begin
                mem[i] <= wdata;
            end
        end
    end

    assign rdata = (int'(index) < DEPTH) ? mem[index] : '0;
endmodule : dam_ram

// File: rtl/dam_core_mem.sv
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module dam_core_mem #(
    parameter int PC_W = dam_pkg::PC_W,
    parameter int NUM_BANKS = dam_pkg::NUM_BANKS,
    parameter int BANK_SIZE = dam_pkg::BANK_SIZE
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic core_req,
    output logic core_ready,
    input wire logic core_write,
    input wire logic core_wsel_alu,
    input wire logic core_to_acc,
    input wire logic [7:0] core_addr,
    output logic [7:0] core_rdata,
    output logic core_rvalid,
    input wire logic alu_valid,
    input wire logic [7:0] alu_result,
    input wire logic tbl_req,
    output logic tbl_ready,
    input wire logic [7:0] tbl_dest,
    output logic pm_req,
    output logic [PC_W-1:0] pm_addr,
    input wire logic pm_valid,
    input wire logic [15:0] pm_data,
    input wire logic pc_step,
    output logic [PC_W-1:0] prog_counter,
    output logic jump_taken,
    output logic dummy_cycle,
    output logic [7:0] accumulator,
    input wire logic wdt_timeout,
    input wire logic halt_exec,
    input wire logic clr_wdt,
    input wire logic wake_event,
    output logic timeout_flag,
    output logic power_down_flag,
    output logic sleeping
);
    localparam int RAM_DEPTH = NUM_BANKS * BANK_SIZE;
    localparam int RAM_AW = $clog2(RAM_DEPTH);

    initial begin
        if (PC_W < 9 || NUM_BANKS < 1 || NUM_BANKS > 16 || BANK_SIZE != 256 - int'(dam_pkg::SFR_TOP)) begin
            $error("dam_core_mem: unsupported geometry");
        end
    end

    // ****************************************
    // State
    // ****************************************
    dam_pkg::dam_state_e state_reg;
    logic [7:0] acc_reg;
    logic [7:0] pointer_a_reg;
    logic [7:0] pointer_b_reg;
    logic [3:0] bank_select_reg;
    logic [7:0] table_pointer_reg;
    logic [7:0] table_high_byte_reg;
    logic [PC_W-1:0] pc_reg;
    logic [7:0] tbl_dest_reg;
    logic timeout_reg;
    logic pdf_reg;
    logic sleep_reg;
    logic jump_reg;
    logic [7:0] core_rdata_reg;
    logic core_rvalid_reg;
    logic [31:0] prdata_reg;

    // ****************************************
    // Request acceptance
    // ****************************************
    logic idle;
    logic core_go;
    logic tbl_go;
    logic tbl_done;
    logic mem_we;
    logic [7:0] mem_addr;
    logic [7:0] mem_wdata;
    logic warm;

    assign idle = (state_reg == dam_pkg::DAM_IDLE);
    assign core_ready = idle && pce;
    assign tbl_ready = idle && pce && !core_req;
    assign core_go = core_req && core_ready;
    assign tbl_go = tbl_req && tbl_ready;
    assign tbl_done = (state_reg == dam_pkg::DAM_TBL_FETCH) && pm_valid && pce;
    assign warm = wdt_timeout && pce;
    assign mem_addr = tbl_done ? tbl_dest_reg : core_addr;
    assign mem_we = (core_go && core_write) || tbl_done;
    // Write data never comes from data memory; a table read writes program memory data
    always_comb begin
        if (tbl_done) begin
            mem_wdata = pm_data[7:0]; // RQ16
        end else if (core_wsel_alu) begin
            mem_wdata = alu_result; // RQ13
        end else begin
            mem_wdata = acc_reg; // RQ13
        end
    end

    // ****************************************
    // Address resolution and storage
    // ****************************************
    logic sfr_sel;
    logic ram_sel;
    logic [7:0] sfr_addr;
    logic [RAM_AW-1:0] ram_index;
    logic [7:0] ram_rdata;
    logic sfr_we;

    dam_addr_map #(.RAM_AW(RAM_AW)) u_map (
        .addr(mem_addr),
        .pointer_a(pointer_a_reg),
        .pointer_b(pointer_b_reg),
        .bank_select(bank_select_reg),
        .sfr_sel(sfr_sel),
        .ram_sel(ram_sel),
        .sfr_addr(sfr_addr),
        .ram_index(ram_index)
    );

    dam_ram #(.WIDTH(dam_pkg::DATA_W), .DEPTH(RAM_DEPTH), .AW(RAM_AW)) u_ram (
        .pclk(pclk),
        .pce(pce),
        .we(mem_we && ram_sel),
        .index(ram_index),
        .wdata(mem_wdata),
        .rdata(ram_rdata)
    );

    assign sfr_we = mem_we && sfr_sel;

    logic [7:0] read_byte;
    always_comb begin
        read_byte = dam_pkg::BYTE_ZERO; // RQ1
        if (ram_sel) begin
            read_byte = ram_rdata;
        end else if (sfr_sel) begin
            unique case (sfr_addr)
                dam_pkg::SFR_POINTER_A: read_byte = pointer_a_reg; // RQ10
                dam_pkg::SFR_POINTER_B: read_byte = pointer_b_reg; // RQ10
                dam_pkg::SFR_BANK_SELECT: read_byte = {4'h0, bank_select_reg};
                dam_pkg::SFR_ACCUMULATOR: read_byte = acc_reg;
                dam_pkg::SFR_PC_LOW: read_byte = pc_reg[7:0];
                dam_pkg::SFR_TABLE_PTR: read_byte = table_pointer_reg;
                dam_pkg::SFR_TABLE_HIGH: read_byte = table_high_byte_reg;
                default: read_byte = dam_pkg::BYTE_ZERO;
            endcase
        end
    end

    // ****************************************
    // APB decode
    // ****************************************
    logic apb_setup;
    logic apb_wr;
    logic apb_hit;
    assign apb_setup = psel && !penable && pce;
    assign apb_wr = psel && penable && pwrite && pce;
    assign pready = pce;
    always_comb begin
        unique case (paddr)
            dam_pkg::APB_BANK_SELECT, dam_pkg::APB_POINTER_A, dam_pkg::APB_POINTER_B,
            dam_pkg::APB_ACCUMULATOR, dam_pkg::APB_TABLE_PTR, dam_pkg::APB_TABLE_HIGH,
            dam_pkg::APB_PROG_COUNTER, dam_pkg::APB_STATUS: apb_hit = 1'b1;
            default: apb_hit = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !apb_hit;

    logic [31:0] apb_rword;
    always_comb begin
        apb_rword = dam_pkg::WORD_ZERO;
        unique case (paddr)
            dam_pkg::APB_BANK_SELECT: apb_rword = {28'h000_0000, bank_select_reg};
            dam_pkg::APB_POINTER_A: apb_rword = {24'h00_0000, pointer_a_reg};
            dam_pkg::APB_POINTER_B: apb_rword = {24'h00_0000, pointer_b_reg};
            dam_pkg::APB_ACCUMULATOR: apb_rword = {24'h00_0000, acc_reg};
            dam_pkg::APB_TABLE_PTR: apb_rword = {24'h00_0000, table_pointer_reg};
            dam_pkg::APB_TABLE_HIGH: apb_rword = {24'h00_0000, table_high_byte_reg};
            dam_pkg::APB_PROG_COUNTER: apb_rword = 32'(pc_reg);
            dam_pkg::APB_STATUS: begin
                apb_rword[dam_pkg::STAT_TIMEOUT] = timeout_reg;
                apb_rword[dam_pkg::STAT_POWER_DOWN] = pdf_reg;
                apb_rword[dam_pkg::STAT_SLEEP] = sleep_reg;
            end
            default: apb_rword = dam_pkg::WORD_ZERO;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= dam_pkg::WORD_ZERO;
        end else if (apb_setup) begin
            prdata_reg <= apb_rword;
        end
    end

    // ****************************************
    // Pointers, table pointer, bank select
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pointer_a_reg <= dam_pkg::BYTE_ZERO;
            pointer_b_reg <= dam_pkg::BYTE_ZERO;
            table_pointer_reg <= dam_pkg::BYTE_ZERO;
        end else if (sfr_we && sfr_addr == dam_pkg::SFR_POINTER_A) begin
            pointer_a_reg <= mem_wdata; // RQ10
        end else if (sfr_we && sfr_addr == dam_pkg::SFR_POINTER_B) begin
            pointer_b_reg <= mem_wdata; // RQ10
        end else if (sfr_we && sfr_addr == dam_pkg::SFR_TABLE_PTR) begin
            table_pointer_reg <= mem_wdata;
        end else if (apb_wr && paddr == dam_pkg::APB_POINTER_A) begin
            pointer_a_reg <= pwdata[7:0];
        end else if (apb_wr && paddr == dam_pkg::APB_POINTER_B) begin
            pointer_b_reg <= pwdata[7:0];
        end else if (apb_wr && paddr == dam_pkg::APB_TABLE_PTR) begin
            table_pointer_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_select_reg <= 4'h0; // RQ7
        end else if (warm) begin
            if (!sleep_reg) begin
                bank_select_reg <= 4'h0; // RQ7
            end
        end else if (sfr_we && sfr_addr == dam_pkg::SFR_BANK_SELECT) begin
            bank_select_reg <= mem_wdata[3:0]; // RQ6
        end else if (apb_wr && paddr == dam_pkg::APB_BANK_SELECT) begin
            bank_select_reg <= pwdata[3:0]; // RQ6
        end
    end

    // ****************************************
    // Accumulator
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg <= dam_pkg::BYTE_ZERO;
        end else if (sfr_we && sfr_addr == dam_pkg::SFR_ACCUMULATOR) begin
            acc_reg <= mem_wdata;
        end else if (core_go && !core_write && core_to_acc) begin
            acc_reg <= read_byte; // RQ13
        end else if (alu_valid && pce) begin
            acc_reg <= alu_result; // RQ13
        end
    end

    // ****************************************
    // Core read return
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_rdata_reg <= dam_pkg::BYTE_ZERO;
            core_rvalid_reg <= 1'b0;
        end else if (pce) begin
            core_rvalid_reg <= core_go && !core_write;
            if (core_go && !core_write) begin
                core_rdata_reg <= read_byte; // RQ3
            end
        end
    end

    // ****************************************
    // Table read and sequencing
    // ****************************************
    logic pcl_write;
    assign pcl_write = sfr_we && sfr_addr == dam_pkg::SFR_PC_LOW;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= dam_pkg::DAM_IDLE;
            tbl_dest_reg <= dam_pkg::BYTE_ZERO;
        end else if (warm) begin
            state_reg <= dam_pkg::DAM_IDLE;
        end else if (pce) begin
            unique case (state_reg)
                dam_pkg::DAM_IDLE: begin
                    if (pcl_write) begin
                        state_reg <= dam_pkg::DAM_DUMMY; // RQ12
                    end else if (tbl_go) begin
                        state_reg <= dam_pkg::DAM_TBL_FETCH; // RQ15
                        tbl_dest_reg <= tbl_dest;
                    end
                end
                dam_pkg::DAM_TBL_FETCH: begin
                    if (pm_valid) begin
                        state_reg <= pcl_write ? dam_pkg::DAM_DUMMY : dam_pkg::DAM_IDLE; // RQ12
                    end
                end
                dam_pkg::DAM_DUMMY: begin
                    state_reg <= dam_pkg::DAM_IDLE; // RQ12
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            table_high_byte_reg <= dam_pkg::BYTE_ZERO;
        end else if (tbl_done) begin
            table_high_byte_reg <= pm_data[15:8]; // RQ15
        end else if (sfr_we && sfr_addr == dam_pkg::SFR_TABLE_HIGH) begin
            table_high_byte_reg <= mem_wdata;
        end
    end

    // ****************************************
    // Program counter
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_reg <= '0;
            jump_reg <= 1'b0;
        end else if (warm) begin
            pc_reg <= '0;
            jump_reg <= 1'b0;
        end else if (pce) begin
            jump_reg <= pcl_write;
            if (pcl_write) begin
                pc_reg <= {pc_reg[PC_W-1:8], mem_wdata}; // RQ11
            end else if (apb_wr && paddr == dam_pkg::APB_PROG_COUNTER) begin
                pc_reg <= pwdata[PC_W-1:0];
            end else if (pc_step) begin
                pc_reg <= pc_reg + 1'b1;
            end
        end
    end

    // ****************************************
    // Watchdog and power-down flags
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_reg <= 1'b0;
            pdf_reg <= 1'b0;
            sleep_reg <= 1'b0;
        end else if (pce) begin
            if (wdt_timeout) begin
                timeout_reg <= 1'b1; // RQ17
            end else if (clr_wdt || halt_exec) begin
                timeout_reg <= 1'b0;
            end
            if (halt_exec) begin
                pdf_reg <= 1'b1;
            end else if (clr_wdt) begin
                pdf_reg <= 1'b0;
            end
            if (wdt_timeout || wake_event) begin
                sleep_reg <= 1'b0;
            end else if (halt_exec) begin
                sleep_reg <= 1'b1;
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata = prdata_reg;
    assign core_rdata = core_rdata_reg;
    assign core_rvalid = core_rvalid_reg;
    assign pm_req = (state_reg == dam_pkg::DAM_TBL_FETCH);
    assign pm_addr = {pc_reg[PC_W-1:8], table_pointer_reg}; // RQ19
    assign prog_counter = pc_reg;
    assign jump_taken = jump_reg;
    assign dummy_cycle = (state_reg == dam_pkg::DAM_DUMMY);
    assign accumulator = acc_reg;
    assign timeout_flag = timeout_reg;
    assign power_down_flag = pdf_reg;
    assign sleeping = sleep_reg;
endmodule : dam_core_mem

// File: dv/dam_pm_model.sv
`timescale 1ns/1ps
module dam_pm_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pm_req,
    input wire logic [13:0] pm_addr,
    input wire logic [3:0] pm_wait,
    output logic pm_valid,
    output logic [15:0] pm_data
);
    // ****
    // Program memory answer
    // ****
    logic [3:0] cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 4'h0;
            pm_valid <= 1'b0;
        end else begin
            cnt <= (pm_req && !pm_valid) ? cnt + 4'h1 : 4'h0;
            pm_valid <= pm_req && !pm_valid && cnt >= pm_wait;
        end
    end
    // Idle bus shows inverse
    assign pm_data = pm_valid ? {2'h1, pm_addr} : ~{2'h1, pm_addr};
endmodule : dam_pm_model

// File: dv/dam_core_mem_asserts.sv
`timescale 1ns/1ps
module dam_core_mem_chk #(
    parameter int PC_W = 14
) (
    input logic pclk,
    input logic presetn,
    input logic pce,
    input logic core_req,
    input logic core_ready,
    input logic core_write,
    input logic core_wsel_alu,
    input logic [7:0] core_addr,
    input logic core_rvalid,
    input logic alu_valid,
    input logic [7:0] alu_result,
    input logic [7:0] accumulator,
    input logic tbl_req,
    input logic tbl_ready,
    input logic pm_req,
    input logic [PC_W-1:0] pm_addr,
    input logic pm_valid,
    input logic [PC_W-1:0] prog_counter,
    input logic jump_taken,
    input logic dummy_cycle,
    input logic wdt_timeout,
    input logic timeout_flag
);
    // ****
    // Checks
    // ****
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic take;
    assign take = core_req && core_ready;
    sequence s_pcl_wr;
        take && core_write && core_addr == dam_pkg::SFR_PC_LOW;
    endsequence
    sequence s_tbl_take;
        tbl_req && tbl_ready;
    endsequence
    property p_pcl_dummy; s_pcl_wr |=> jump_taken && dummy_cycle; endproperty
    a_pcl_dummy: assert property (p_pcl_dummy) else $error("No dummy cycle after jump");
    property p_dummy_stall; dummy_cycle |-> !core_ready && !tbl_ready; endproperty
    a_dummy_stall: assert property (p_dummy_stall) else $error("Taken in dummy cycle");
    property p_pcl_page;
        s_pcl_wr |=> prog_counter == {$past(prog_counter[PC_W-1:8]),
            ($past(core_wsel_alu) ? $past(alu_result) : $past(accumulator))};
    endproperty
    a_pcl_page: assert property (p_pcl_page) else $error("Jump target wrong");
    property p_tbl_page; pm_req |-> pm_addr[PC_W-1:8] == prog_counter[PC_W-1:8]; endproperty
    a_tbl_page: assert property (p_tbl_page) else $error("Table page wrong");
    property p_tbl_start; s_tbl_take |=> pm_req; endproperty
    a_tbl_start: assert property (p_tbl_start) else $error("Table fetch not started");
    property p_tbl_end; pm_req && pm_valid |=> !pm_req; endproperty
    a_tbl_end: assert property (p_tbl_end) else $error("Table fetch not ended");
    property p_acc_alu; alu_valid && pce && !take && !pm_valid |=> accumulator == $past(alu_result); endproperty
    a_acc_alu: assert property (p_acc_alu) else $error("Accumulator missed result");
    property p_timeout; wdt_timeout && pce |=> timeout_flag; endproperty
    a_timeout: assert property (p_timeout) else $error("Timeout flag not set");
    property p_rd_ans; take && !core_write |=> core_rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("Read not answered");
endmodule : dam_core_mem_chk
bind dam_core_mem dam_core_mem_chk #(.PC_W(PC_W)) i_chk (.*);

// File: dv/tb_dam_core_mem.sv
`timescale 1ns/1ps
module tb_dam_core_mem;
    logic pclk = 1'b0, presetn = 1'b0, pce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic core_req = 1'b0, core_write = 1'b0, core_wsel_alu = 1'b0, core_to_acc = 1'b0, alu_valid = 1'b0;
    logic tbl_req = 1'b0, pc_step = 1'b0, wdt_timeout = 1'b0, halt_exec = 1'b0, clr_wdt = 1'b0, wake_event = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [7:0] core_addr = 8'h00, alu_result = 8'h00, tbl_dest = 8'h00, core_rdata, accumulator, r8;
    logic [13:0] pm_addr, prog_counter;
    logic [15:0] pm_data;
    logic [3:0] pm_wait = 4'h0;
    logic pready, pslverr, core_ready, core_rvalid, tbl_ready, pm_req, pm_valid, jump_taken, dummy_cycle;
    logic timeout_flag, power_down_flag, sleeping;
    int err_total = 0, tests_run = 0;
    dam_core_mem i_dam_core_mem (.*);
    dam_pm_model i_dam_pm_model (.*);
    always #2.5 pclk = ~pclk;
    // ****
    // Tasks
    // ****
    task automatic chk(input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask : rdc
    task automatic bnk(input logic [3:0] b);
        apb(1'b1, dam_pkg::APB_BANK_SELECT, 32'(b));
    endtask : bnk
    task automatic core(input logic w, input logic [7:0] a, input logic to_acc);
        @(posedge pclk);
        core_req <= 1'b1;
        core_write <= w;
        core_addr <= a;
        core_to_acc <= to_acc;
        do @(posedge pclk); while (core_ready !== 1'b1);
        core_req <= 1'b0;
        @(posedge pclk);
        r8 = core_rdata;
    endtask : core
    task automatic get(input logic [7:0] a, e);
        core(1'b0, a, 1'b0);
        chk(r8, e);
    endtask : get
    task automatic put(input logic [7:0] a, v);
        @(posedge pclk);
        alu_valid <= 1'b1;
        alu_result <= v;
        @(posedge pclk);
        alu_valid <= 1'b0;
        core(1'b1, a, 1'b0);
    endtask : put
    task automatic tbl(input logic [7:0] dst);
        @(posedge pclk);
        tbl_req <= 1'b1;
        tbl_dest <= dst;
        do @(posedge pclk); while (tbl_ready !== 1'b1);
        tbl_req <= 1'b0;
        do @(posedge pclk); while (pm_req !== 1'b0);
    endtask : tbl
    task automatic wdt(input logic h);
        @(posedge pclk);
        halt_exec <= h;
        @(posedge pclk);
        halt_exec <= 1'b0;
        wdt_timeout <= 1'b1;
        @(posedge pclk);
        wdt_timeout <= 1'b0;
    endtask : wdt
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict
    // ****
    // Tests
    // ****
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdc(dam_pkg::APB_BANK_SELECT, 32'h0000_0000);
        put(dam_pkg::SFR_POINTER_A, 8'h47);
        rdc(dam_pkg::APB_POINTER_A, 32'h0000_0047);
        apb(1'b1, dam_pkg::APB_POINTER_B, 32'h0000_0047);
        for (int b = 0; b < 11; b++) begin
            bnk(4'(b));
            put(dam_pkg::SFR_PORT_B, 8'(8'hA0 + b));
        end
        for (int b = 10; b >= 0; b--) begin
            bnk(4'(b));
            get(dam_pkg::SFR_PORT_B, 8'(8'hA0 + b));
        end
        bnk(4'h3);
        put(8'h47, 8'h11);
        get(dam_pkg::SFR_PORT_A, 8'h11);
        get(dam_pkg::SFR_PORT_B, 8'hA3);
        get(dam_pkg::SFR_POINTER_B, 8'h47);
        apb(1'b1, dam_pkg::APB_POINTER_A, 32'h0000_0000);
        get(dam_pkg::SFR_PORT_A, 8'h00);
        put(dam_pkg::SFR_PORT_A, 8'h55);
        rdc(dam_pkg::APB_POINTER_A, 32'h0000_0000);
        rdc(dam_pkg::APB_BANK_SELECT, 32'h0000_0003);
        core(1'b0, 8'h47, 1'b1);
        rdc(dam_pkg::APB_ACCUMULATOR, 32'h0000_0011);
        apb(1'b1, dam_pkg::APB_PROG_COUNTER, 32'h0000_0523);
        alu_result <= 8'h9C;
        core_wsel_alu <= 1'b1;
        core(1'b1, dam_pkg::SFR_PC_LOW, 1'b0);
        core_wsel_alu <= 1'b0;
        rdc(dam_pkg::APB_PROG_COUNTER, 32'h0000_059C);
        apb(1'b1, dam_pkg::APB_TABLE_PTR, 32'h0000_003A);
        for (int w = 0; w < 2; w++) begin
            pm_wait <= 4'(w * 3);
            tbl(8'h48);
            rdc(dam_pkg::APB_TABLE_HIGH, 32'h0000_0045);
            get(8'h48, 8'h3A);
        end
        bnk(4'h6);
        wdt(1'b0);
        rdc(dam_pkg::APB_BANK_SELECT, 32'h0000_0000);
        rdc(dam_pkg::APB_STATUS, 32'h0000_0001);
        bnk(4'h6);
        wdt(1'b1);
        rdc(dam_pkg::APB_BANK_SELECT, 32'h0000_0006);
        rdc(dam_pkg::APB_STATUS, 32'h0000_0003);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(dam_pkg::APB_BANK_SELECT, 32'h0000_0000);
        print_verdict();
    end
    initial begin
        #50us;
        err_total++;
        print_verdict();
    end
endmodule : tb_dam_core_mem
